// file: hdl/media_link_defines.vh
`ifndef MEDIA_LINK_DEFINES_VH
`define MEDIA_LINK_DEFINES_VH
// Media selection codes reported on the status field.
`define MEDIA_NONE        2'h0
`define MEDIA_COPPER      2'h1
`define MEDIA_SERDES      2'h2
// Preference bit values.
`define PREF_COPPER       1'b0
`define PREF_SERDES       1'b1
// Powered-device detection status codes.
`define PD_SEARCH         2'h0
`define PD_FOUND          2'h1
`define PD_TIMEOUT        2'h2
// Crossover force codes (two-bit masked field).
`define XOVER_AUTO        2'h0
`define XOVER_STRAIGHT    2'h2
`define XOVER_CROSSED     2'h3
// Speed codes from the forced speed select bits {13,6}.
`define SPEED_10          2'h0
`define SPEED_100         2'h1
`define SPEED_1000        2'h2
// Loopback wait time in microseconds and derived cycle count at 20 MHz.
`define PD_WAIT_US        1000
`define CLK_MHZ           20
`define PD_WAIT_CYCLES    (`PD_WAIT_US * `CLK_MHZ)
// Default failed gigabit attempts before downshift.
`define DOWNSHIFT_DEFAULT 3'h2
`endif

// file: hdl/pd_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "media_link_defines.vh"
module pd_detect #(
	parameter WAIT_CYCLES = `PD_WAIT_CYCLES
) (
	// Clock and reset
	input  wire       clk,
	input  wire       srst,
	input  wire       ce,
	// Control
	input  wire       pd_enable,
	input  wire       aneg_enable,
	input  wire       loopback_seen,
	input  wire       link_up,
	input  wire       irq_read,
	// Status
	output reg  [1:0] pd_status_r,
	output reg        pd_active_r,
	output reg        pd_irq_r
);
	localparam ST_IDLE   = 2'h0;
	localparam ST_SEARCH = 2'h1;
	localparam ST_NORMAL = 2'h2;
	localparam ST_LINKED = 2'h3;
	reg [1:0]  state_r;
	reg [31:0] wait_r;
	always @(posedge clk) begin
		if (srst) begin
			state_r     <= ST_IDLE;
			wait_r      <= 32'h0;
			pd_status_r <= `PD_SEARCH;
			pd_active_r <= 1'b0;
			pd_irq_r    <= 1'b0;
		end else if (ce) begin
			// A new detection beats a read in the same cycle.
			if (state_r == ST_SEARCH && loopback_seen)
				pd_irq_r <= 1'b1;
			else if (irq_read)
				pd_irq_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (pd_enable && aneg_enable) begin
					state_r     <= ST_SEARCH;
					wait_r      <= 32'h0;
					pd_status_r <= `PD_SEARCH;
					pd_active_r <= 1'b1;
				end
			end
			ST_SEARCH: begin
				if (!pd_enable || !aneg_enable) begin
					state_r     <= ST_IDLE;
					pd_active_r <= 1'b0;
				end else if (loopback_seen) begin
					pd_status_r <= `PD_FOUND;
				end else if (pd_status_r == `PD_SEARCH) begin
					if (wait_r >= WAIT_CYCLES - 1) begin
						pd_status_r <= `PD_TIMEOUT;
						pd_active_r <= 1'b0;
						state_r     <= ST_NORMAL;
					end else begin
						wait_r <= wait_r + 32'h1;
					end
				end
			end
			ST_NORMAL: begin
				// Link must come up first, then a drop restarts detection.
				if (link_up)
					state_r <= ST_LINKED;
			end
			ST_LINKED: begin
				// Searching again while linked would tear the link down, so wait for the drop.
				if (!link_up) begin
					if (pd_enable && aneg_enable) begin
						state_r     <= ST_SEARCH;
						wait_r      <= 32'h0;
						pd_status_r <= `PD_SEARCH;
						pd_active_r <= 1'b1;
					end else begin
						state_r <= ST_IDLE;
					end
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // pd_detect
`default_nettype wire

// file: hdl/media_link_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "media_link_defines.vh"
module media_link_ctrl #(
	parameter PD_WAIT_CYCLES = `PD_WAIT_CYCLES,
	parameter DS_WIDTH       = 3
) (
	// Clock, reset and enable
	input  wire                clk,
	input  wire                srst,
	input  wire                ce,
	// Media selection configuration
	input  wire                auto_media_select,
	input  wire                media_pref,
	input  wire                serdes_passthru,
	// Media link inputs from the pins
	input  wire                signal_present_input,
	input  wire                serdes_link_in,
	input  wire                serdes_attempt_in,
	input  wire                copper_link_in,
	input  wire                copper_attempt_in,
	// Copper control
	input  wire                aneg_enable,
	input  wire                speed_sel_lsb,
	input  wire                speed_sel_msb,
	input  wire                duplex_force,
	input  wire                next_page_en,
	// Local and link partner abilities {1000F,1000H,100F,100H,10F,10H}
	input  wire [5:0]          local_ability,
	input  wire [5:0]          link_partner_ability,
	input  wire                link_partner_aneg,
	input  wire                link_partner_np,
	input  wire                local_master_pref,
	input  wire                link_partner_master_pref,
	input  wire [1:0]          parallel_speed_in,
	// Crossover and polarity
	input  wire [1:0]          xover_force,
	input  wire                xover_disable,
	input  wire                polarity_disable,
	input  wire                forced_xover_disable,
	input  wire [1:0]          pair_ab_swap_in,
	input  wire [1:0]          pair_cd_swap_in,
	input  wire [3:0]          pair_inverted_in,
	// Downshift
	input  wire                downshift_en,
	input  wire [DS_WIDTH-1:0] downshift_limit,
	input  wire                giga_attempt_fail,
	// Powered-device detection
	input  wire                pd_enable,
	input  wire                pd_loopback_in,
	input  wire                pd_irq_read,
	// Status
	output reg  [1:0]          media_sel_r,
	output reg                 copper_drop_r,
	output reg                 std_regs_serdes_r,
	output reg                 link_up_r,
	output reg  [1:0]          speed_r,
	output reg                 duplex_r,
	output reg                 master_r,
	output reg                 np_exchange_r,
	output reg                 parallel_det_r,
	output reg                 mdix_r,
	output reg                 cd_swap_r,
	output reg  [3:0]          polarity_fix_r,
	output reg                 downshifted_r,
	output wire [5:0]          adv_ability,
	output wire [1:0]          pd_status,
	output wire                pd_active,
	output wire                pd_irq
);
	// Two-stage synchronisers for the pin inputs other than parallel_speed_in, the ability words and link_partner_master_pref.
	localparam NSYNC = 17;
	wire [NSYNC-1:0] raw = {signal_present_input, serdes_link_in, serdes_attempt_in, copper_link_in,
		copper_attempt_in, pd_loopback_in, pair_ab_swap_in, pair_cd_swap_in, pair_inverted_in,
		giga_attempt_fail, link_partner_aneg, link_partner_np};
	reg [NSYNC-1:0] s1_r;
	reg [NSYNC-1:0] s2_r;
	always @(posedge clk) begin
		if (srst) begin
			s1_r <= {NSYNC{1'b0}};
			s2_r <= {NSYNC{1'b0}};
		end else if (ce) begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end
	wire       sig_present   = s2_r[16];
	wire       serdes_lnk_a  = s2_r[15];
	wire       serdes_try    = s2_r[14];
	wire       copper_lnk    = s2_r[13];
	wire       copper_try    = s2_r[12];
	wire       pd_loop       = s2_r[11];
	wire [1:0] ab_swap       = s2_r[10:9];
	wire [1:0] cd_swap       = s2_r[8:7];
	wire [3:0] inverted      = s2_r[6:3];
	wire       giga_fail     = s2_r[2];
	wire       lp_aneg       = s2_r[1];
	wire       lp_np         = s2_r[0];

	// In pass-through the MAC owns the serdes link; the pin alone says up.
	wire serdes_lnk = serdes_passthru ? sig_present : serdes_lnk_a;

	// Media selection; copper is dropped while serdes is preferred and linked.
	reg [1:0] sel_nxt;
	always @* begin
		sel_nxt = `MEDIA_NONE;
		if (!auto_media_select)
			sel_nxt = serdes_passthru ? `MEDIA_SERDES : `MEDIA_COPPER;
		else if (media_pref == `PREF_SERDES) begin
			if (serdes_lnk)
				sel_nxt = `MEDIA_SERDES;
			else if (copper_lnk)
				sel_nxt = (serdes_try && media_sel_r != `MEDIA_COPPER) ? `MEDIA_SERDES : `MEDIA_COPPER;
			else if (serdes_try)
				sel_nxt = `MEDIA_SERDES;
		end else begin
			if (copper_lnk || copper_try)
				sel_nxt = `MEDIA_COPPER;
			else if (serdes_lnk)
				sel_nxt = `MEDIA_SERDES;
		end
	end

	// Ability resolution, highest common wins.
	function [2:0] best;
		input [5:0] a;
		begin
			best = a[5] ? 3'h5 : a[4] ? 3'h4 : a[3] ? 3'h3 : a[2] ? 3'h2 : a[1] ? 3'h1 : a[0] ? 3'h0 : 3'h7;
		end
	endfunction

	// Downshift: after the limit of failures, the gigabit bits go off advertising.
	reg [DS_WIDTH-1:0] fail_cnt_r;
	reg                fail_d_r;
	assign adv_ability = downshifted_r ? {2'b00, local_ability[3:0]} : local_ability;
	wire [5:0] common  = adv_ability & link_partner_ability;
	wire [2:0] res     = best(common);

	wire copper_ok    = copper_lnk && !(media_pref == `PREF_SERDES && auto_media_select && serdes_lnk);
	wire xover_run    = !xover_disable && (aneg_enable || (!forced_xover_disable && speed_r != `SPEED_1000));
	wire [1:0] forced_speed = {speed_sel_msb, speed_sel_lsb};

	wire [1:0] pd_st;
	pd_detect #(
		.WAIT_CYCLES (PD_WAIT_CYCLES)
	) u_pd (
		.clk           (clk),
		.srst          (srst),
		.ce            (ce),
		.pd_enable     (pd_enable),
		.aneg_enable   (aneg_enable),
		.loopback_seen (pd_loop),
		.link_up       (link_up_r),
		.irq_read      (pd_irq_read),
		.pd_status_r   (pd_st),
		.pd_active_r   (pd_active),
		.pd_irq_r      (pd_irq)
	);
	assign pd_status = pd_st;

	always @(posedge clk) begin
		if (srst) begin
			media_sel_r       <= `MEDIA_NONE;
			copper_drop_r     <= 1'b0;
			std_regs_serdes_r <= 1'b0;
			link_up_r         <= 1'b0;
			speed_r           <= `SPEED_10;
			duplex_r          <= 1'b0;
			master_r          <= 1'b0;
			np_exchange_r     <= 1'b0;
			parallel_det_r    <= 1'b0;
			mdix_r            <= 1'b0;
			cd_swap_r         <= 1'b0;
			polarity_fix_r    <= 4'h0;
			downshifted_r     <= 1'b0;
			fail_cnt_r        <= {DS_WIDTH{1'b0}};
			fail_d_r          <= 1'b0;
		end else if (ce) begin
			media_sel_r   <= sel_nxt;
			copper_drop_r <= copper_lnk && !copper_ok;
			// Standard status shows serdes only in autoneg serdes mode.
			std_regs_serdes_r <= auto_media_select && !serdes_passthru && sel_nxt == `MEDIA_SERDES;
			if (sel_nxt == `MEDIA_SERDES)
				link_up_r <= serdes_lnk;
			else
				link_up_r <= copper_ok && !pd_active;
			if (!aneg_enable) begin
				speed_r        <= forced_speed;
				duplex_r       <= duplex_force;
				parallel_det_r <= 1'b0;
			end else if (!lp_aneg) begin
				speed_r        <= parallel_speed_in;
				duplex_r       <= 1'b0;
				parallel_det_r <= 1'b1;
			end else if (res != 3'h7) begin
				speed_r        <= (res >= 3'h4) ? `SPEED_1000 : (res >= 3'h2) ? `SPEED_100 : `SPEED_10;
				duplex_r       <= res[0];
				parallel_det_r <= 1'b0;
			end
			// Gigabit role: preference mismatch decides, ties leave slave.
			master_r      <= aneg_enable && res >= 3'h4 && local_master_pref && !link_partner_master_pref;
			np_exchange_r <= aneg_enable && next_page_en && lp_np;
			// Crossover: forced code beats detection; detection copes with C/D swaps.
			if (xover_force == `XOVER_STRAIGHT) begin
				mdix_r <= 1'b0;
			end else if (xover_force == `XOVER_CROSSED) begin
				mdix_r <= 1'b1;
			end else if (xover_run) begin
				mdix_r    <= ab_swap[0] & ab_swap[1];
				cd_swap_r <= cd_swap[0] & cd_swap[1];
			end else begin
				// Without detection the port falls back to straight wiring.
				mdix_r    <= 1'b0;
				cd_swap_r <= 1'b0;
			end
			polarity_fix_r <= polarity_disable ? 4'h0 : inverted;
			fail_d_r <= giga_fail;
			if (!downshift_en || link_up_r) begin
				fail_cnt_r <= {DS_WIDTH{1'b0}};
				if (!downshift_en)
					downshifted_r <= 1'b0;
			end else if (giga_fail && !fail_d_r && !downshifted_r) begin
				if (fail_cnt_r + 1'b1 >= downshift_limit)
					downshifted_r <= 1'b1;
				fail_cnt_r <= fail_cnt_r + 1'b1;
			end
		end
	end
endmodule // media_link_ctrl
`default_nettype wire

// file: sim/media_link_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module media_link_ctrl_props (
	// Clock and reset
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       ce,
	// Configuration and pins
	input wire logic       auto_media_select,
	input wire logic       media_pref,
	input wire logic       serdes_passthru,
	input wire logic       signal_present_input,
	input wire logic       serdes_link_in,
	input wire logic       copper_link_in,
	input wire logic       aneg_enable,
	input wire logic       speed_sel_lsb,
	input wire logic       speed_sel_msb,
	input wire logic       duplex_force,
	input wire logic       pd_enable,
	// Status
	input wire logic [1:0] media_sel_r,
	input wire logic [1:0] speed_r,
	input wire logic       duplex_r,
	input wire logic       downshifted_r,
	input wire logic [5:0] adv_ability,
	input wire logic [1:0] pd_status,
	input wire logic       pd_active,
	input wire logic       pd_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sel_code_a: assert property (media_sel_r != 2'h3)
		else $error("Media code out of range.");
	// Four samples cover the two synchroniser flops and the output register.
	copper_pref_a: assert property (
		(ce && auto_media_select && !media_pref && copper_link_in && !pd_active)[*4] |-> media_sel_r == 2'h1)
		else $error("Linked copper not selected.");
	serdes_pref_a: assert property (
		(ce && auto_media_select && media_pref && serdes_link_in && !serdes_passthru)[*4] |-> media_sel_r == 2'h2)
		else $error("Preferred serdes not selected.");
	passthru_up_a: assert property (
		(ce && auto_media_select && media_pref && serdes_passthru && signal_present_input)[*4]
		|-> media_sel_r == 2'h2) else $error("Pass-through link ignored.");
	forced_speed_a: assert property (
		ce && !aneg_enable && !(speed_sel_msb && speed_sel_lsb) |=> speed_r == {$past(speed_sel_msb),
		$past(speed_sel_lsb)} && duplex_r == $past(duplex_force)) else $error("Forced speed wrong.");
	downshift_adv_a: assert property (downshifted_r |-> adv_ability[5:4] == 2'h0)
		else $error("Gigabit still advertised.");
	pd_start_a: assert property ($rose(pd_active) |-> $past(pd_enable && aneg_enable))
		else $error("Detection started unasked.");
	pd_irq_found_a: assert property ($rose(pd_irq) |-> pd_status == 2'h1)
		else $error("Interrupt without detection.");
	pd_timeout_off_a: assert property (pd_status == 2'h2 |-> !pd_active)
		else $error("Detection on after timeout.");
	cover property ($rose(pd_irq));
	cover property (pd_status == 2'h2);
	cover property (downshifted_r);
endmodule // media_link_ctrl_props
bind media_link_ctrl media_link_ctrl_props i_media_link_ctrl_props (.*);
`default_nettype wire

// file: sim/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
	// Clock
	input  wire logic clk,
	// Probe from the device and power state
	input  wire logic probe_on,
	input  wire logic powered_down,
	// Returned pulses
	output var  logic loop_back
);
	// Only an unpowered partner passes pulses back; once powered it stops at the next clock edge.
	always @(posedge clk) begin
		loop_back <= probe_on && powered_down;
	end
endmodule // link_partner_model
`default_nettype wire

// file: sim/media_link_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "media_link_defines.vh"
module media_link_ctrl_tb;
	localparam int W = 16;
	logic       clk, srst, ce, auto_media_select, media_pref, serdes_passthru, signal_present_input;
	logic       serdes_link_in, serdes_attempt_in, copper_link_in, copper_attempt_in, next_page_en;
	logic       aneg_enable, speed_sel_lsb, speed_sel_msb, duplex_force, link_partner_aneg, link_partner_np;
	logic       local_master_pref, link_partner_master_pref, xover_disable, polarity_disable;
	logic       forced_xover_disable, downshift_en, giga_attempt_fail, pd_enable, pd_loopback_in;
	logic       pd_irq_read, lp_powered_down, copper_drop_r, std_regs_serdes_r, link_up_r, duplex_r;
	logic       master_r, np_exchange_r, parallel_det_r, mdix_r, cd_swap_r, downshifted_r, pd_active, pd_irq;
	logic [5:0] local_ability, link_partner_ability, adv_ability;
	logic [1:0] parallel_speed_in, xover_force, pair_ab_swap_in, pair_cd_swap_in;
	logic [1:0] media_sel_r, speed_r, pd_status;
	logic [3:0] pair_inverted_in, polarity_fix_r;
	logic [2:0] downshift_limit;
	int         n_errors, n_checks;
	media_link_ctrl #(.PD_WAIT_CYCLES(W)) i_media_link_ctrl (.*);
	link_partner_model i_link_partner_model (.clk(clk), .probe_on(pd_active),
		.powered_down(lp_powered_down), .loop_back(pd_loopback_in));
	always #25 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic media(input logic p, input logic [3:0] links, input logic [1:0] exp);
		{copper_link_in, copper_attempt_in, serdes_link_in, serdes_attempt_in} = links;
		media_pref = p;
		cyc(5);
		chk(media_sel_r, exp);
	endtask
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_media;
		auto_media_select = 1;
		media(1, 4'h0, `MEDIA_NONE);
		media(1, 4'h8, `MEDIA_COPPER);
		media(1, 4'h9, `MEDIA_COPPER);
		media(1, 4'ha, `MEDIA_SERDES);
		chk(copper_drop_r, 1);
		media(1, 4'h6, `MEDIA_SERDES);
		media(0, 4'h6, `MEDIA_COPPER);
		media(0, 4'ha, `MEDIA_COPPER);
		chk(copper_drop_r, 0);
		media(0, 4'h2, `MEDIA_SERDES);
		chk(std_regs_serdes_r, 1);
		$display("test media done");
	endtask
	task automatic t_pass;
		{serdes_passthru, signal_present_input} = 2'h3;
		media(1, 4'h0, `MEDIA_SERDES);
		chk(std_regs_serdes_r, 0);
		signal_present_input = 0;
		media(1, 4'h0, `MEDIA_NONE);
		serdes_passthru = 0;
		$display("test passthru done");
	endtask
	task automatic t_aneg;
		{aneg_enable, local_master_pref, link_partner_aneg, local_ability} = {3'h7, 6'h3f};
		link_partner_ability = 6'h3f;
		media(0, 4'h8, `MEDIA_COPPER);
		chk({link_up_r, speed_r, duplex_r, master_r}, {1'b1, `SPEED_1000, 2'h3});
		link_partner_ability = 6'h0e;
		cyc(5);
		chk({speed_r, duplex_r}, {`SPEED_100, 1'b1});
		link_partner_ability = 6'h05;
		cyc(5);
		chk({speed_r, duplex_r}, {`SPEED_100, 1'b0});
		{link_partner_aneg, parallel_speed_in} = {1'b0, `SPEED_100};
		cyc(5);
		chk({parallel_det_r, speed_r, duplex_r}, {1'b1, `SPEED_100, 1'b0});
		{link_partner_aneg, next_page_en, link_partner_np} = 3'h7;
		cyc(5);
		chk(np_exchange_r, 1);
		next_page_en = 0;
		cyc(5);
		chk(np_exchange_r, 0);
		ce = 0;
		next_page_en = 1;
		cyc(5);
		chk(np_exchange_r, 0);
		ce = 1;
		next_page_en = 0;
		cyc(2);
		$display("test aneg done");
	endtask
	task automatic t_forced;
		{aneg_enable, pair_ab_swap_in} = 3'h3;
		for (int s = 2; s >= 0; s--) begin
			{speed_sel_msb, speed_sel_lsb, duplex_force} = {s[1:0], s[0]};
			cyc(5);
			chk({speed_r, duplex_r}, {s[1:0], s[0]});
		end
		chk(mdix_r, 1);
		forced_xover_disable = 1;
		cyc(5);
		chk(mdix_r, 0);
		$display("test forced done");
	endtask
	task automatic t_xover;
		{aneg_enable, pair_cd_swap_in, pair_inverted_in} = {3'h7, 4'ha};
		cyc(5);
		chk({mdix_r, cd_swap_r, polarity_fix_r}, 6'h3a);
		xover_force = `XOVER_STRAIGHT;
		cyc(5);
		chk(mdix_r, 0);
		{xover_force, pair_ab_swap_in} = {`XOVER_CROSSED, 2'h0};
		cyc(5);
		chk(mdix_r, 1);
		{xover_force, pair_ab_swap_in, xover_disable, polarity_disable} = {`XOVER_AUTO, 4'hf};
		cyc(5);
		chk({mdix_r, polarity_fix_r}, 0);
		$display("test xover done");
	endtask
	task automatic t_down;
		copper_link_in = 0;
		cyc(5);
		{downshift_en, downshift_limit} = {1'b1, 3'h2};
		for (int i = 0; i < 2; i++) begin
			giga_attempt_fail = 1;
			cyc(4);
			giga_attempt_fail = 0;
			cyc(5);
			chk({downshifted_r, adv_ability}, {i[0], i ? 6'h0f : 6'h3f});
		end
		$display("test downshift done");
	endtask
	task automatic t_pd;
		pd_enable = 1;
		media(0, 4'h0, `MEDIA_NONE);
		chk({pd_active, pd_status}, {1'b1, `PD_SEARCH});
		lp_powered_down = 1;
		cyc(6);
		chk({pd_status, pd_irq}, {`PD_FOUND, 1'b1});
		lp_powered_down = 0;
		cyc(5);
		pd_irq_read = 1;
		cyc(1);
		pd_irq_read = 0;
		cyc(1);
		chk(pd_irq, 0);
		srst = 1;
		cyc(3);
		srst = 0;
		cyc(W - 4);
		chk({pd_active, pd_status}, {1'b1, `PD_SEARCH});
		cyc(10);
		chk({pd_active, pd_status}, {1'b0, `PD_TIMEOUT});
		media(0, 4'h8, `MEDIA_COPPER);
		chk(link_up_r, 1);
		media(0, 4'h0, `MEDIA_NONE);
		chk({pd_active, pd_status}, {1'b1, `PD_SEARCH});
		$display("test pd done");
	endtask
	initial begin
		{clk, srst, ce} = 3'h3;
		{auto_media_select, media_pref, serdes_passthru, signal_present_input, serdes_link_in} = '0;
		{serdes_attempt_in, copper_link_in, copper_attempt_in, next_page_en, aneg_enable} = '0;
		{speed_sel_lsb, speed_sel_msb, duplex_force, link_partner_aneg, link_partner_np} = '0;
		{local_master_pref, link_partner_master_pref, xover_disable, polarity_disable} = '0;
		{forced_xover_disable, downshift_en, giga_attempt_fail, pd_enable, pd_irq_read} = '0;
		{lp_powered_down, local_ability, link_partner_ability, parallel_speed_in, xover_force} = '0;
		{pair_ab_swap_in, pair_cd_swap_in, pair_inverted_in, downshift_limit} = '0;
		{n_errors, n_checks} = '0;
		cyc(12);
		chk({media_sel_r, pd_status, link_up_r, pd_irq, pd_active}, 0);
		srst = 0;
		cyc(1);
		t_media;
		t_pass;
		t_aneg;
		t_forced;
		t_xover;
		t_down;
		t_pd;
		wrap_up;
	end
endmodule // media_link_ctrl_tb
`default_nettype wire
